// ===== core/async_base_clock_select_pkg.sv
package async_base_clock_select_pkg;

    // Register byte addresses on the APB slave
    localparam logic [11:0] ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE = 12'h000;
    localparam logic [11:0] ASYNC_BASE_CLOCK_SELECT_ADDR_SER_MODE = 12'h004;
    localparam logic [11:0] ASYNC_BASE_CLOCK_SELECT_ADDR_STATUS = 12'h008;

    // Field positions
    localparam int ASYNC_BASE_CLOCK_SELECT_BIT_BASE_CLK_SEL = 7;
    localparam int ASYNC_BASE_CLOCK_SELECT_BIT_SYNC_MODE = 7;

    // Reset values
    localparam logic [7:0] ASYNC_BASE_CLOCK_SELECT_EXT_MODE_RST = 8'h00;
    localparam logic [7:0] ASYNC_BASE_CLOCK_SELECT_SER_MODE_RST = 8'h00;

    // Last and mid-bit basic clock count values within a bit period
    localparam logic [3:0] ASYNC_BASE_CLOCK_SELECT_LAST_X16 = 4'hf;
    localparam logic [3:0] ASYNC_BASE_CLOCK_SELECT_LAST_X8 = 4'h7;
    localparam logic [3:0] ASYNC_BASE_CLOCK_SELECT_MID_X16 = 4'h7;
    localparam logic [3:0] ASYNC_BASE_CLOCK_SELECT_MID_X8 = 4'h3;

endpackage : async_base_clock_select_pkg

// ===== core/async_base_clock_select_top.sv
// Operation
// - Eight-bit extended serial mode register, readable and writable by software.
// - Bit 7 selects basic clock cycles per bit in asynchronous mode.
// - Bit 7 at 0: sixteen basic clock cycles per bit.
// - Bit 7 at 1: eight basic clock cycles per bit, doubling rate.
// - Bit 7 honoured only while serial mode selects asynchronous operation.
// - Extended register clears to zero on reset.
// - Bits 6 to 0 read zero; software writes only zero.
`timescale 1ns/1ps

module async_base_clock_select_top
    import async_base_clock_select_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Basic clock tick from the baud generator
    input wire logic base_tick,
    // Bit timing to transmitter and receiver
    output logic bit_end,
    output logic rx_sample,
    output logic sync_mode
);

    typedef struct packed {
        logic base_clk_sel;
        logic sync_sel;
        logic [3:0] cnt;
        logic bit_end;
        logic rx_sample;
        logic [31:0] rdata;
    } async_base_clock_select_state_t;

    async_base_clock_select_state_t st_q;
    async_base_clock_select_state_t st_d;

    logic acc;
    logic wr;
    logic mapped;
    logic fast;
    logic [3:0] last;
    logic [3:0] mid;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and bit timing
    always_comb
    begin
        acc = psel && penable;
        wr = acc && pwrite;
        mapped = (paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE) || (paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_SER_MODE)
            || (paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_STATUS);
        fast = st_q.base_clk_sel && !st_q.sync_sel;
        last = fast ? ASYNC_BASE_CLOCK_SELECT_LAST_X8 : ASYNC_BASE_CLOCK_SELECT_LAST_X16;
        mid = fast ? ASYNC_BASE_CLOCK_SELECT_MID_X8 : ASYNC_BASE_CLOCK_SELECT_MID_X16;
        st_d = st_q;
        st_d.bit_end = 1'b0;
        st_d.rx_sample = 1'b0;
        if (wr && paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE)
        begin
            st_d.base_clk_sel = pwdata[ASYNC_BASE_CLOCK_SELECT_BIT_BASE_CLK_SEL];
        end
        if (wr && paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_SER_MODE)
        begin
            st_d.sync_sel = pwdata[ASYNC_BASE_CLOCK_SELECT_BIT_SYNC_MODE];
        end
        st_d.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE: st_d.rdata[ASYNC_BASE_CLOCK_SELECT_BIT_BASE_CLK_SEL] = st_q.base_clk_sel;
                ASYNC_BASE_CLOCK_SELECT_ADDR_SER_MODE: st_d.rdata[ASYNC_BASE_CLOCK_SELECT_BIT_SYNC_MODE] = st_q.sync_sel;
                ASYNC_BASE_CLOCK_SELECT_ADDR_STATUS: st_d.rdata[3:0] = st_q.cnt;
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
        else if (acc)
        begin
            st_d.rdata = st_q.rdata;
        end
        if (base_tick)
        begin
            st_d.cnt = (st_q.cnt >= last) ? 4'h0 : st_q.cnt + 4'h1;
            st_d.bit_end = (st_q.cnt >= last);
            st_d.rx_sample = (st_q.cnt == mid);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q.base_clk_sel <= ASYNC_BASE_CLOCK_SELECT_EXT_MODE_RST[ASYNC_BASE_CLOCK_SELECT_BIT_BASE_CLK_SEL];
            st_q.sync_sel <= ASYNC_BASE_CLOCK_SELECT_SER_MODE_RST[ASYNC_BASE_CLOCK_SELECT_BIT_SYNC_MODE];
            st_q.cnt <= 4'h0;
            st_q.bit_end <= 1'b0;
            st_q.rx_sample <= 1'b0;
            st_q.rdata <= 32'h0000_0000;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.rdata;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign bit_end = st_q.bit_end;
    assign rx_sample = st_q.rx_sample;
    assign sync_mode = st_q.sync_sel;

    ////////////////////////////////////////////////////////////////////////
    // Checks: register access
    ext_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE |=> st_q.base_clk_sel == $past(pwdata[7]))
        else $error("extended register write lost");

    ext_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && !penable && !pwrite && paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE
        ##1 psel && penable |-> prdata[7] == $past(st_q.base_clk_sel))
        else $error("extended register readback wrong");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(psel && !penable && paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE) |-> prdata[6:0] == 7'h00)
        else $error("reserved bits read nonzero");

    upper_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        prdata[31:8] == 24'h00_0000)
        else $error("upper read bits nonzero");

    idle_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        !psel |=> prdata == 32'h0000_0000)
        else $error("read data not cleared when idle");

    bad_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && !mapped
        |=> $stable(st_q.base_clk_sel) && $stable(st_q.sync_sel))
        else $error("unmapped write changed a register");

    ser_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr && paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_SER_MODE
        |=> sync_mode == $past(pwdata[ASYNC_BASE_CLOCK_SELECT_BIT_SYNC_MODE]))
        else $error("serial mode write lost");

    ser_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && !penable && !pwrite && paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_SER_MODE
        |=> prdata[ASYNC_BASE_CLOCK_SELECT_BIT_SYNC_MODE] == $past(st_q.sync_sel))
        else $error("serial mode readback wrong");

    status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && !penable && !pwrite && paddr == ASYNC_BASE_CLOCK_SELECT_ADDR_STATUS
        |=> prdata[3:0] == $past(st_q.cnt))
        else $error("counter readback wrong");

    ext_clear_a: assert property (@(posedge clk)
        !rst_n
        |-> st_q.base_clk_sel == 1'b0 && prdata == 32'h0000_0000)
        else $error("extended register not cleared in reset");

    ////////////////////////////////////////////////////////////////////////
    // Checks: bit timing
    wrap_x16_a: assert property (@(posedge clk) disable iff (!rst_n)
        base_tick && !fast && st_q.cnt == 4'hf |=> bit_end && st_q.cnt == 4'h0)
        else $error("x16 wrap missed");

    wrap_x8_a: assert property (@(posedge clk) disable iff (!rst_n)
        base_tick && fast && st_q.cnt == 4'h7 |=> bit_end && st_q.cnt == 4'h0)
        else $error("x8 wrap missed");

    sync_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_q.sync_sel |-> !fast)
        else $error("select honoured in sync mode");

    sync_x16_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_q.sync_sel && base_tick && st_q.cnt == ASYNC_BASE_CLOCK_SELECT_LAST_X8
        |=> !bit_end && st_q.cnt == 4'h8)
        else $error("short bit period in sync mode");

    cnt_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        fast && $past(fast) && $past(base_tick) |-> st_q.cnt <= ASYNC_BASE_CLOCK_SELECT_LAST_X8)
        else $error("x8 counter overran");

    tick_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        base_tick && st_q.cnt < last
        |=> st_q.cnt == $past(st_q.cnt) + 4'h1)
        else $error("counter did not advance on tick");

    no_tick_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !base_tick
        |=> $stable(st_q.cnt) && !bit_end && !rx_sample)
        else $error("bit timing moved without tick");

    bit_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        bit_end |=> !bit_end)
        else $error("bit end longer than one cycle");

    x8_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
        base_tick && fast && st_q.cnt == ASYNC_BASE_CLOCK_SELECT_MID_X8 |=> rx_sample)
        else $error("x8 mid sample missed");

    x16_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
        base_tick && !fast && st_q.cnt == ASYNC_BASE_CLOCK_SELECT_MID_X16 |=> rx_sample)
        else $error("x16 mid sample missed");

    mid_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
        rx_sample
        |-> $past(st_q.cnt) == (fast ? ASYNC_BASE_CLOCK_SELECT_MID_X8 : ASYNC_BASE_CLOCK_SELECT_MID_X16) || $past(fast) != fast)
        else $error("sample not at mid count");

endmodule : async_base_clock_select_top

// ===== dv/async_base_clock_select_far_end.sv
`timescale 1ns/1ps
module async_base_clock_select_far_end (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bit timing
    input wire logic bit_end,
    input wire logic rx_sample,
    output logic base_tick,
    output logic [31:0] per_bit,
    output logic [31:0] to_mid
);
    logic [31:0] cnt;
    // Ticks every other cycle; counts ticks per bit and up to mid sample
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            {base_tick, cnt, per_bit, to_mid} <= '0;
        else
        begin
            base_tick <= !base_tick;
            cnt <= bit_end ? 32'h0 : cnt + 32'(base_tick);
            if (bit_end) per_bit <= cnt;
            if (rx_sample) to_mid <= cnt;
        end
    end
endmodule : async_base_clock_select_far_end

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import async_base_clock_select_pkg::*;
;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, base_tick, err;
    logic pready, pslverr, bit_end, rx_sample, sync_mode;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, per_bit, to_mid;
    int bad_count = 0, check_count = 0;
    initial forever #5 clk = ~clk;
    async_base_clock_select_top async_base_clock_select_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .base_tick(base_tick), .bit_end(bit_end),
        .rx_sample(rx_sample), .sync_mode(sync_mode));
    async_base_clock_select_far_end async_base_clock_select_far_end_inst (.clk(clk), .rst_n(rst_n), .bit_end(bit_end),
        .rx_sample(rx_sample), .base_tick(base_tick), .per_bit(per_bit), .to_mid(to_mid));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            bad_count++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic t_regs;
        apb(0, ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE, 32'h0);
        chk(rd, 32'h0);
        apb(1, ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE, 32'h80);
        apb(0, ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE, 32'h0);
        chk(rd, 32'h80);
        apb(1, 12'h00c, 32'hff);
        chk(32'(err), 32'h1);
        $display("regs done");
    endtask : t_regs
    task automatic t_rate(input logic [31:0] ser, input logic [31:0] ext, input logic [31:0] n);
        apb(1, ASYNC_BASE_CLOCK_SELECT_ADDR_SER_MODE, ser);
        apb(1, ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE, ext);
        repeat (100) @(posedge clk);
        chk(per_bit, n);
        chk(to_mid, n >> 1);
        chk(32'(sync_mode), ser >> 7);
        $display("rate %0d done", n);
    endtask : t_rate
    task automatic t_reset;
        apb(1, ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE, 32'h80);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, ASYNC_BASE_CLOCK_SELECT_ADDR_EXT_MODE, 32'h0);
        chk(rd, 32'h0);
        $display("reset done");
    endtask : t_reset
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_rate(32'h0, 32'h80, 32'h8);
        t_rate(32'h0, 32'h0, 32'h10);
        t_rate(32'h80, 32'h80, 32'h10);
        t_rate(32'h80, 32'h0, 32'h10);
        t_reset();
        end_sim();
    end
endmodule : tb_top
